// *** logic/mailbox_threshold_interrupts.sv ***
// Threshold compare, event capture, mask and interrupt output for one mailbox port.
// Assumes FIFO levels and sticky error flags arrive synchronous to clock from the
// surrounding mailbox, and a single-cycle register strobe from the port's bus logic.
//
// Contract
// - Send threshold is read/write, resets to zero, low THR_W bits implemented.
// - Receive threshold is read/write, resets to zero, low THR_W bits implemented.
// - Writing send threshold re-evaluates send flag; a rise raises send event.
// - Writing receive threshold re-evaluates receive flag; a rise raises receive event.
// - Any error flag becoming set sets the error event bit.
// - Receive event is set on each rise of receive flag, not steady level.
// - Send event is set on each rise of send flag, not steady level.
// - Status holds error, receive and send events; all reset to zero.
// - Writing one clears a status bit, writing zero keeps it; reads show events.
// - Mask register is read/write over the three event bits, resets to zero.
// - Pending reads as status AND mask on the same bit positions.
// - Pending is read only; writes complete without changing state.
// - Interrupt output is the OR of all pending bits.
// - Other bits of status, mask and pending are reserved with no function.
// - Receive flag is high when receive level exceeds receive threshold.
// - Send flag is high when send level is at or below send threshold.

`timescale 1ns/1ps
`default_nettype none

module mailbox_threshold_interrupts (
  input  wire logic                            clock,
  input  wire logic                            arst_n,
  input  wire mailbox_irq_pkg::reg_req_s       reg_req,
  output var  mailbox_irq_pkg::reg_rsp_s       reg_rsp,
  input  wire logic [mailbox_irq_pkg::LEVEL_W-1:0] send_fifo_level,
  input  wire logic [mailbox_irq_pkg::LEVEL_W-1:0] recv_fifo_level,
  input  wire logic [mailbox_irq_pkg::ERRF_W-1:0]  error_flags,
  output logic                                 send_threshold_active,
  output logic                                 recv_threshold_active,
  output logic                                 irq
);
  import mailbox_irq_pkg::*;

  // ******************************************************************
  // Address decode
  // ******************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  logic [THR_W-1:0]  send_irq_threshold_q;
  logic [THR_W-1:0]  recv_irq_threshold_q;
  logic [IRQ_W-1:0]  irq_event_status_q;
  logic [IRQ_W-1:0]  irq_event_status_d;
  logic [IRQ_W-1:0]  irq_mask_enable_q;
  logic [IRQ_W-1:0]  irq_pending;
  logic              send_active_prev_q;
  logic              recv_active_prev_q;
  logic [ERRF_W-1:0] error_prev_q;
  reg_rsp_s          rsp_d;

  // Strobes per register
  wire logic send_thr_wr = reg_req.wr && hit(reg_req.addr, OFF_SEND_THR);
  wire logic recv_thr_wr = reg_req.wr && hit(reg_req.addr, OFF_RECV_THR);
  wire logic status_wr   = reg_req.wr && hit(reg_req.addr, OFF_STATUS);
  wire logic mask_wr     = reg_req.wr && hit(reg_req.addr, OFF_MASK);
  wire logic pending_wr  = reg_req.wr && hit(reg_req.addr, OFF_PENDING);
  wire logic pending_rd  = reg_req.rd && hit(reg_req.addr, OFF_PENDING);

  // ******************************************************************
  // Threshold flags and edge detection
  // ******************************************************************
  // Compares use the live register, so a threshold write moves the flag next cycle
  assign send_threshold_active = (send_fifo_level <= {1'b0, send_irq_threshold_q});
  assign recv_threshold_active = (recv_fifo_level >  {1'b0, recv_irq_threshold_q});

  // Rise against last cycle's value; a held level gives no new event
  wire logic sta_rise = send_threshold_active && !send_active_prev_q;
  wire logic rta_rise = recv_threshold_active && !recv_active_prev_q;
  wire logic err_rise = |(error_flags & ~error_prev_q);

  wire logic [IRQ_W-1:0] events = {err_rise, rta_rise, sta_rise};

  // Write-one clear mask; zeros in the written word leave bits alone
  wire logic [IRQ_W-1:0] clear_mask = status_wr ? reg_req.wdata[IRQ_W-1:0] : IRQ_RST;

  // Set wins over clear so an event arriving during acknowledge is kept
  assign irq_event_status_d = (irq_event_status_q & ~clear_mask) | events;

  // Pending view and the port's interrupt line
  assign irq_pending = irq_event_status_q & irq_mask_enable_q;
  assign irq         = |irq_pending;

  // ******************************************************************
  // Read path
  // ******************************************************************
  // Reserved and unmapped bits read as zero
  wire logic [DATA_W-1:0] rd_mux =
      hit(reg_req.addr, OFF_SEND_THR) ? {{(DATA_W-THR_W){1'b0}}, send_irq_threshold_q} :
      hit(reg_req.addr, OFF_RECV_THR) ? {{(DATA_W-THR_W){1'b0}}, recv_irq_threshold_q} :
      hit(reg_req.addr, OFF_STATUS)   ? {{(DATA_W-IRQ_W){1'b0}}, irq_event_status_q}   :
      hit(reg_req.addr, OFF_MASK)     ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask_enable_q}    :
      hit(reg_req.addr, OFF_PENDING)  ? {{(DATA_W-IRQ_W){1'b0}}, irq_pending}          :
      WORD_ZERO;

  // Answer one cycle after the strobe; rdata holds until the next read
  always_comb begin
    rsp_d.ack   = reg_req.wr || reg_req.rd;
    rsp_d.rdata = reg_req.rd ? rd_mux : reg_rsp.rdata;
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  // Threshold and mask storage; a pending write matches nothing here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      send_irq_threshold_q <= THR_RST;
      recv_irq_threshold_q <= THR_RST;
      irq_mask_enable_q    <= IRQ_RST;
    end else begin
      if (send_thr_wr) send_irq_threshold_q <= reg_req.wdata[THR_W-1:0];
      if (recv_thr_wr) recv_irq_threshold_q <= reg_req.wdata[THR_W-1:0];
      if (mask_wr)     irq_mask_enable_q    <= reg_req.wdata[IRQ_W-1:0];
    end
  end

  // Event status and the previous-flag copies used by the edge detectors
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_event_status_q <= IRQ_RST;
      send_active_prev_q <= 1'b0;
      recv_active_prev_q <= 1'b0;
      error_prev_q       <= ERRF_RST;
    end else begin
      irq_event_status_q <= irq_event_status_d;
      send_active_prev_q <= send_threshold_active;
      recv_active_prev_q <= recv_threshold_active;
      error_prev_q       <= error_flags;
    end
  end

  // Bus answer flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp <= rsp_d;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_send_thr_store;
    send_thr_wr |=> send_irq_threshold_q == $past(reg_req.wdata[THR_W-1:0]);
  endproperty
  a_send_thr_store: assert property (p_send_thr_store)
    else $error("send threshold did not take the written value");

  property p_recv_thr_store;
    recv_thr_wr |=> recv_irq_threshold_q == $past(reg_req.wdata[THR_W-1:0]);
  endproperty
  a_recv_thr_store: assert property (p_recv_thr_store)
    else $error("receive threshold did not take the written value");

  property p_send_flag_ends;
    (send_fifo_level == '0 |-> send_threshold_active) and
    (send_fifo_level == LEVEL_FULL |-> !send_threshold_active);
  endproperty
  a_send_flag_ends: assert property (p_send_flag_ends)
    else $error("send flag wrong at empty or full level");

  property p_recv_flag_ends;
    (recv_fifo_level == '0 |-> !recv_threshold_active) and
    (recv_fifo_level == LEVEL_FULL |-> recv_threshold_active);
  endproperty
  a_recv_flag_ends: assert property (p_recv_flag_ends)
    else $error("receive flag wrong at empty or full level");

  property p_send_thr_write_edge;
    (send_thr_wr && !send_threshold_active &&
     (send_fifo_level <= {1'b0, reg_req.wdata[THR_W-1:0]}))
    ##1 (send_fifo_level == $past(send_fifo_level)) |=> irq_event_status_q[BIT_STI];
  endproperty
  a_send_thr_write_edge: assert property (p_send_thr_write_edge)
    else $error("send threshold write did not raise send event");

  property p_recv_thr_write_edge;
    (recv_thr_wr && !recv_threshold_active &&
     (recv_fifo_level > {1'b0, reg_req.wdata[THR_W-1:0]}))
    ##1 (recv_fifo_level == $past(recv_fifo_level)) |=> irq_event_status_q[BIT_RTI];
  endproperty
  a_recv_thr_write_edge: assert property (p_recv_thr_write_edge)
    else $error("receive threshold write did not raise receive event");

  property p_err_event;
    (error_flags != ERRF_RST) && ($past(error_flags) == ERRF_RST)
    |=> irq_event_status_q[BIT_ERR];
  endproperty
  a_err_event: assert property (p_err_event)
    else $error("error flag rise did not set error event");

  property p_send_rise_event;
    $rose(send_threshold_active) |=> irq_event_status_q[BIT_STI];
  endproperty
  a_send_rise_event: assert property (p_send_rise_event)
    else $error("send flag rise did not set send event");

  property p_recv_rise_event;
    $rose(recv_threshold_active) |=> irq_event_status_q[BIT_RTI];
  endproperty
  a_recv_rise_event: assert property (p_recv_rise_event)
    else $error("receive flag rise did not set receive event");

  property p_steady_no_event;
    ($past(arst_n) && recv_threshold_active && $past(recv_threshold_active) &&
     status_wr && reg_req.wdata[BIT_RTI]) |=> !irq_event_status_q[BIT_RTI];
  endproperty
  a_steady_no_event: assert property (p_steady_no_event)
    else $error("steady receive level set the event again");

  property p_w1c_clear;
    status_wr |=> (irq_event_status_q & $past(clear_mask & ~events)) == IRQ_RST;
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("writing one did not clear status bit");

  property p_w0_keep;
    status_wr |=> (irq_event_status_q & $past(irq_event_status_q & ~clear_mask)) ==
                  $past(irq_event_status_q & ~clear_mask);
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("writing zero changed a status bit");

  property p_set_wins;
    (events != IRQ_RST) |=> (irq_event_status_q & $past(events)) == $past(events);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("new event lost against a clear");

  property p_mask_store;
    mask_wr |=> irq_mask_enable_q == $past(reg_req.wdata[IRQ_W-1:0]);
  endproperty
  a_mask_store: assert property (p_mask_store)
    else $error("mask did not take the written value");

  property p_pending_read;
    pending_rd |=> reg_rsp.ack &&
      (reg_rsp.rdata[IRQ_W-1:0] == $past(irq_event_status_q & irq_mask_enable_q));
  endproperty
  a_pending_read: assert property (p_pending_read)
    else $error("pending read is not status AND mask");

  property p_pending_ro;
    (pending_wr && !mask_wr) |=> reg_rsp.ack && $stable(irq_mask_enable_q) &&
      $stable(send_irq_threshold_q) && $stable(recv_irq_threshold_q);
  endproperty
  a_pending_ro: assert property (p_pending_ro)
    else $error("pending write changed state or got no answer");

  property p_irq_holds;
    (irq && !status_wr && !mask_wr) |=> irq;
  endproperty
  a_irq_holds: assert property (p_irq_holds)
    else $error("interrupt dropped without acknowledge");

  property p_reserved_zero;
    reg_req.rd && (hit(reg_req.addr, OFF_STATUS) || hit(reg_req.addr, OFF_MASK) ||
                   pending_rd) |=> reg_rsp.rdata[DATA_W-1:IRQ_W] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

  // ******************************************************************
  // Bus answer timing and steady levels
  // ******************************************************************
  // The strobe protocol never stalls, so every strobe owes exactly one answer
  property p_ack_follows;
    (reg_req.wr || reg_req.rd) |=> reg_rsp.ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("bus strobe got no answer");

  property p_ack_idle;
    !(reg_req.wr || reg_req.rd) |=> !reg_rsp.ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("bus answer without a strobe");

  property p_rdata_hold;
    !reg_req.rd |=> $stable(reg_rsp.rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  property p_pending_wr_status;
    pending_wr |=> irq_event_status_q == ($past(irq_event_status_q) | $past(events));
  endproperty
  a_pending_wr_status: assert property (p_pending_wr_status)
    else $error("pending write changed the status");

  // Past reset only: the edge registers restart at zero, so a flag high
  // through reset gives one event at release even though it looks steady
  property p_send_steady_no_event;
    ($past(arst_n) && send_threshold_active && $past(send_threshold_active) &&
     status_wr && reg_req.wdata[BIT_STI]) |=> !irq_event_status_q[BIT_STI];
  endproperty
  a_send_steady_no_event: assert property (p_send_steady_no_event)
    else $error("steady send level set the event again");

  property p_err_steady_no_event;
    ($past(arst_n) && (error_flags == $past(error_flags)) &&
     status_wr && reg_req.wdata[BIT_ERR]) |=> !irq_event_status_q[BIT_ERR];
  endproperty
  a_err_steady_no_event: assert property (p_err_steady_no_event)
    else $error("steady error flags set the event again");

  property p_mask_gates_irq;
    (irq_mask_enable_q == IRQ_RST) |-> !irq;
  endproperty
  a_mask_gates_irq: assert property (p_mask_gates_irq)
    else $error("interrupt raised with every source masked");

  property p_send_flag_equal;
    (send_fifo_level == {1'b0, send_irq_threshold_q}) |-> send_threshold_active;
  endproperty
  a_send_flag_equal: assert property (p_send_flag_equal)
    else $error("send flag low with level equal to threshold");

  property p_recv_flag_equal;
    (recv_fifo_level == {1'b0, recv_irq_threshold_q}) |-> !recv_threshold_active;
  endproperty
  a_recv_flag_equal: assert property (p_recv_flag_equal)
    else $error("receive flag high with level equal to threshold");

  // Main scenarios
  c_send_irq: cover property (irq_mask_enable_q[BIT_STI] && $rose(irq_pending[BIT_STI]));
  c_steady_ack: cover property (send_threshold_active && send_active_prev_q && status_wr);
  c_recv_irq: cover property (irq_mask_enable_q[BIT_RTI] && $rose(irq_pending[BIT_RTI]));
  c_err_irq:  cover property (irq_mask_enable_q[BIT_ERR] && $rose(irq_pending[BIT_ERR]));
  c_set_vs_clear: cover property ((events & clear_mask) != IRQ_RST);

endmodule : mailbox_threshold_interrupts

`default_nettype wire

// *** shared/mailbox_irq_pkg.sv ***
// Constants and carrier types for the mailbox port interrupt and threshold block.
// Assumes one bus clock per port; bit positions are little-endian (bit 0 = LSB).
package mailbox_irq_pkg;

  // ******************************************************************
  // Sizes
  // ******************************************************************
  localparam int DEPTH   = 16;                 // Mailbox FIFO depth
  localparam int THR_W   = $clog2(DEPTH);      // Implemented threshold bits
  localparam int LEVEL_W = THR_W + 1;          // Level spans 0 .. DEPTH
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 32;
  localparam int IRQ_W   = 3;
  localparam int ERRF_W  = 2;                  // Sticky error flags: full, empty

  // ******************************************************************
  // Register offsets (byte addresses)
  // ******************************************************************
  localparam logic [ADDR_W-1:0] OFF_SEND_THR = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_RECV_THR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_MASK     = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_PENDING  = 6'h28;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int BIT_STI = 0;                  // Send threshold event
  localparam int BIT_RTI = 1;                  // Receive threshold event
  localparam int BIT_ERR = 2;                  // Error event
  localparam logic [THR_W-1:0]  THR_RST  = 4'h0;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;
  localparam logic [ERRF_W-1:0] ERRF_RST = 2'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 5'h10;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // ******************************************************************
  // Carrier types
  // ******************************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_s;

endpackage : mailbox_irq_pkg

// *** bench/bus_master_model.sv ***
// Processor bus master model for one mailbox port: strobes and acknowledge writes.
// Assumes the block acks every strobe one cycle later and never stalls.
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  input  wire logic                      clock,
  output var  mailbox_irq_pkg::reg_req_s reg_req,
  input  wire mailbox_irq_pkg::reg_rsp_s reg_rsp
);
  import mailbox_irq_pkg::*;

  // ******************************************************************
  // Accesses
  // ******************************************************************
  // Bus starts idle
  initial begin
    reg_req = '0;
  end

  // One-cycle strobe; on release address and data flip so a stale value never looks held.
  // The answer is taken at the edge that samples ack high, before that edge moves it.
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output reg_rsp_s rsp);
    @(posedge clock);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clock);
    rsp = reg_rsp;
  endtask : access

  // Service acknowledge: a one in each serviced status bit
  task automatic ack_events(input logic [IRQ_W-1:0] bits);
    reg_rsp_s rsp;
    access(1'b1, OFF_STATUS, WORD_ZERO | bits, rsp);
  endtask : ack_events
endmodule : bus_master_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the mailbox port interrupt block: random plus corner cases.
// Assumes the bus master model owns the register port; levels and errors come from here.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(name, exp, act) \
  begin \
    check_count++; \
    if ((act) !== (exp)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", name, exp, act); \
    end \
  end

module tb_top;
  import mailbox_irq_pkg::*;

  logic               clock;
  logic               arst_n;
  reg_req_s           reg_req;
  reg_rsp_s           reg_rsp;
  logic [LEVEL_W-1:0] send_fifo_level;
  logic [LEVEL_W-1:0] recv_fifo_level;
  logic [ERRF_W-1:0]  error_flags;
  logic               send_threshold_active;
  logic               recv_threshold_active;
  logic               irq;
  int                 fail_count;
  int                 check_count;
  logic [DATA_W-1:0]  d;
  logic [DATA_W-1:0]  e;
  reg_rsp_s           rsp;
  logic [ADDR_W-1:0]  offs [5] = '{OFF_SEND_THR, OFF_RECV_THR, OFF_STATUS, OFF_MASK, OFF_PENDING};

  mailbox_threshold_interrupts u_mailbox_threshold_interrupts (
    .clock(clock), .arst_n(arst_n), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .send_fifo_level(send_fifo_level), .recv_fifo_level(recv_fifo_level),
    .error_flags(error_flags), .send_threshold_active(send_threshold_active),
    .recv_threshold_active(recv_threshold_active), .irq(irq));

  bus_master_model u_bus_master_model (.clock(clock), .reg_req(reg_req), .reg_rsp(reg_rsp));

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Free-running 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Expected flags, worked out from level and threshold
  function automatic logic send_exp(input logic [LEVEL_W-1:0] l, input logic [THR_W-1:0] t);
    return l <= LEVEL_W'(t);
  endfunction : send_exp

  function automatic logic recv_exp(input logic [LEVEL_W-1:0] l, input logic [THR_W-1:0] t);
    return l > LEVEL_W'(t);
  endfunction : recv_exp

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    u_bus_master_model.access(1'b1, a, v, rsp);
    `CHECK("wr_ack", 1'b1, rsp.ack)
  endtask : wr

  task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    u_bus_master_model.access(1'b0, a, WORD_ZERO, rsp);
    `CHECK("rd_ack", 1'b1, rsp.ack)
    `CHECK(n, x, rsp.rdata)
  endtask : rd

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    tick(20000);
    fail_count++;
    report_and_stop();
  end

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  // Full send FIFO at release so no event is pending out of reset
  initial begin
    d = $urandom(32'h686a_c4c9);
    arst_n = 1'b0;
    send_fifo_level = LEVEL_FULL;
    recv_fifo_level = '0;
    error_flags = '0;
    fail_count = 0;
    check_count = 0;
    tick(5);
    `CHECK("irq_in_reset", 1'b0, irq)
    arst_n <= 1'b1;
    foreach (offs[i]) begin
      rd("reset_value", offs[i], WORD_ZERO);
    end
    // Random register round trips and flag compares; every third level sits on the threshold
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      e = $urandom;
      wr(OFF_SEND_THR, d);
      rd("send_thr", OFF_SEND_THR, WORD_ZERO | d[THR_W-1:0]);
      wr(OFF_RECV_THR, e);
      rd("recv_thr", OFF_RECV_THR, WORD_ZERO | e[THR_W-1:0]);
      wr(OFF_MASK, e);
      rd("mask", OFF_MASK, WORD_ZERO | e[IRQ_W-1:0]);
      tick(1);
      send_fifo_level <= (i % 3 == 0) ? LEVEL_W'(d[THR_W-1:0]) : LEVEL_W'($urandom_range(16, 0));
      recv_fifo_level <= (i % 3 == 1) ? LEVEL_W'(e[THR_W-1:0]) : LEVEL_W'($urandom_range(16, 0));
      error_flags <= ERRF_W'($urandom);
      tick(1);
      #1;
      `CHECK("send_act", send_exp(send_fifo_level, d[THR_W-1:0]), send_threshold_active)
      `CHECK("recv_act", recv_exp(recv_fifo_level, e[THR_W-1:0]), recv_threshold_active)
    end
    // Threshold writes alone make the flags rise
    wr(OFF_MASK, WORD_ZERO);
    wr(OFF_SEND_THR, 32'h0000_0008);
    wr(OFF_RECV_THR, 32'h0000_000F);
    tick(1);
    send_fifo_level <= 5'h0C;
    recv_fifo_level <= 5'h05;
    error_flags <= '0;
    tick(2);
    u_bus_master_model.ack_events(3'h7);
    rd("status_clear", OFF_STATUS, WORD_ZERO);
    wr(OFF_SEND_THR, 32'h0000_000C);
    rd("send_event", OFF_STATUS, 32'h0000_0001);
    tick(8);
    u_bus_master_model.ack_events(3'h1);
    rd("steady_high", OFF_STATUS, WORD_ZERO);
    wr(OFF_RECV_THR, 32'h0000_0004);
    rd("recv_event", OFF_STATUS, 32'h0000_0002);
    wr(OFF_STATUS, WORD_ZERO);
    rd("write_zero", OFF_STATUS, 32'h0000_0002);
    u_bus_master_model.ack_events(3'h2);
    // Error event, then a second flag rising while the first stays high
    tick(1);
    error_flags <= 2'b01;
    tick(2);
    rd("err_event", OFF_STATUS, 32'h0000_0004);
    u_bus_master_model.ack_events(3'h4);
    tick(1);
    error_flags <= 2'b11;
    tick(2);
    rd("err_second", OFF_STATUS, 32'h0000_0004);
    u_bus_master_model.ack_events(3'h4);
    rd("err_steady", OFF_STATUS, WORD_ZERO);
    // All three events at once, then mask, pending and output
    tick(1);
    error_flags <= '0;
    send_fifo_level <= LEVEL_FULL;
    recv_fifo_level <= '0;
    tick(2);
    u_bus_master_model.ack_events(3'h7);
    tick(1);
    error_flags <= 2'b01;
    send_fifo_level <= '0;
    recv_fifo_level <= 5'h09;
    tick(2);
    rd("all_events", OFF_STATUS, 32'h0000_0007);
    for (int m = 0; m < 8; m++) begin
      wr(OFF_MASK, DATA_W'(m));
      rd("pending", OFF_PENDING, DATA_W'(m));
      `CHECK("irq_or", m != 0, irq)
    end
    wr(OFF_PENDING, WORD_ZERO);
    rd("pend_write", OFF_STATUS, 32'h0000_0007);
    rd("pend_write_mask", OFF_MASK, 32'h0000_0007);
    wr(6'h30, 32'hFFFF_FFFF);
    rd("unmapped", 6'h3C, WORD_ZERO);
    for (int k = 0; k < 3; k++) begin
      u_bus_master_model.ack_events(IRQ_W'(1 << k));
      rd("pend_ack", OFF_PENDING, DATA_W'((7 << (k + 1)) & 7));
      `CHECK("irq_ack", k < 2, irq)
    end
    // New event in the same cycle as its clear keeps the bit
    tick(1);
    send_fifo_level <= LEVEL_FULL;
    tick(2);
    u_bus_master_model.ack_events(3'h7);
    fork
      u_bus_master_model.ack_events(3'h1);
      begin
        @(posedge clock);
        send_fifo_level <= '0;
      end
    join
    rd("event_beats_clear", OFF_STATUS, 32'h0000_0001);
    // Second reset in mid-run
    tick(1);
    arst_n <= 1'b0;
    send_fifo_level <= LEVEL_FULL;
    recv_fifo_level <= '0;
    error_flags <= '0;
    tick(2);
    #1;
    `CHECK("irq_reset", 1'b0, irq)
    tick(1);
    arst_n <= 1'b1;
    rd("status_rst", OFF_STATUS, WORD_ZERO);
    rd("mask_rst", OFF_MASK, WORD_ZERO);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
